// ### src/sotp_access.sv
// Serial command decoder for the secured OTP area and security register.
`timescale 1ns/100ps
module sotp_access (
    // Clock and reset.
    input  wire logic                 core_clk,
    input  wire logic                 arst_n,
    // Serial pins.
    input  wire logic                 spi_cs_n,
    input  wire logic                 spi_sck,
    input  wire logic                 spi_mosi,
    output logic                      spi_miso,
    output logic                      spi_miso_oe,
    // Non-volatile security cells.
    input  wire logic                 nv_factory_lock,
    input  wire logic                 otp_customer_lock_flag,
    output logic                      cust_lock_set,
    // Memory engine.
    output logic                      mem_req_valid,
    output sotp_pkg::sotp_req_type    mem_req,
    input  wire logic [7:0]           mem_rdata,
    // Status.
    output logic                      otp_mode,
    output logic                      cmd_refused
);

    logic [2:0]             sck_sy_q, cs_sy_q, mosi_sy_q;
    logic                   sck_s_q, cs_s_q, mosi_s_q;
    logic                   sck_s_d, cs_s_d, mosi_s_d;
    logic                   sck_rise, sck_fall, cs_rise;
    sotp_pkg::sotp_ctx_type ctx_q, ctx_d;
    sotp_pkg::sotp_req_type req_q, req_d;
    logic                   req_v_q, req_v_d;
    logic                   set_q, set_d;
    logic                   ref_q, ref_d;
    logic [7:0]             sec_value;
    logic [7:0]             rx_byte;
    logic                   rd_go;
    logic [23:0]            rd_addr;

    function automatic logic [7:0] param_byte(input logic [23:0] a);
        if (a == sotp_pkg::PARAM_PROT_ADDR0)
            return sotp_pkg::PARAM_PROT_BYTE0;
        else if (a == sotp_pkg::PARAM_PROT_ADDR1)
            return sotp_pkg::PARAM_PROT_BYTE1;
        return sotp_pkg::BLANK_BYTE;
    endfunction : param_byte

    function automatic sotp_pkg::sotp_req_type mk_req(
        input sotp_pkg::sotp_kind_type k,
        input logic                    otp,
        input logic [23:0]             a,
        input logic [7:0]              d);
        sotp_pkg::sotp_req_type r;
        r.kind                = k;
        r.otp_sel             = otp;
        r.serial_number_field = otp & (a <= sotp_pkg::SERIAL_ADDR_LAST);
        r.addr                = a;
        r.data                = d;
        return r;
    endfunction : mk_req

    // Bits 0 and 1 mirror the non-volatile cells; the rest read as zero.
    always_comb begin
        sec_value = {sotp_pkg::SEC_RSVD_VALUE, 2'b00};
        sec_value[sotp_pkg::SEC_FACTORY_BIT] = nv_factory_lock;
        sec_value[sotp_pkg::SEC_CUST_BIT]    = otp_customer_lock_flag;
    end

    // A pin level is accepted once the second and third stages agree.
    always_comb begin
        sck_s_d  = (sck_sy_q[1] == sck_sy_q[2]) ? sck_sy_q[2] : sck_s_q;
        cs_s_d   = (cs_sy_q[1] == cs_sy_q[2]) ? cs_sy_q[2] : cs_s_q;
        mosi_s_d = (mosi_sy_q[1] == mosi_sy_q[2]) ? mosi_sy_q[2] : mosi_s_q;
        sck_rise = sck_s_d & ~sck_s_q;
        sck_fall = ~sck_s_d & sck_s_q;
        cs_rise  = cs_s_d & ~cs_s_q;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sck_sy_q  <= 3'h0;
            cs_sy_q   <= 3'h7;
            mosi_sy_q <= 3'h0;
            sck_s_q   <= 1'b0;
            cs_s_q    <= 1'b1;
            mosi_s_q  <= 1'b0;
        end else begin
            sck_sy_q  <= {sck_sy_q[1:0], spi_sck};
            cs_sy_q   <= {cs_sy_q[1:0], spi_cs_n};
            mosi_sy_q <= {mosi_sy_q[1:0], spi_mosi};
            sck_s_q   <= sck_s_d;
            cs_s_q    <= cs_s_d;
            mosi_s_q  <= mosi_s_d;
        end
    end

    always_comb begin
        ctx_d   = ctx_q;
        req_d   = req_q;
        req_v_d = 1'b0;
        set_d   = 1'b0;
        ref_d   = 1'b0;
        rd_go   = 1'b0;
        rd_addr = ctx_q.addr;
        rx_byte = {ctx_q.shin[6:0], mosi_s_d};
        if (ctx_q.rd_pend) begin
            ctx_d.txnext  = mem_rdata;
            ctx_d.rd_pend = 1'b0;
        end
        if (cs_rise && ctx_q.state == sotp_pkg::ST_DATA) begin
            if (ctx_q.bitcnt == 3'h0 && ctx_q.got) begin
                case (ctx_q.op)
                    sotp_pkg::OP_SEC_WRITE: begin
                        if (ctx_q.otp_mode || otp_customer_lock_flag)
                            ref_d = 1'b1;
                        else
                            set_d = ctx_q.shin[sotp_pkg::SEC_CUST_BIT];
                    end
                    sotp_pkg::OP_WRSR1, sotp_pkg::OP_WRSR2: begin
                        if (ctx_q.otp_mode) begin
                            ref_d = 1'b1;
                        end else begin
                            req_v_d = 1'b1;
                            req_d   = mk_req((ctx_q.op == sotp_pkg::OP_WRSR1)
                                          ? sotp_pkg::REQ_WRSR1
                                          : sotp_pkg::REQ_WRSR2,
                                          1'b0, ctx_q.addr, ctx_q.shin);
                        end
                    end
                    sotp_pkg::OP_ERASE: begin
                        if (ctx_q.otp_mode) begin
                            ref_d = 1'b1;
                        end else begin
                            req_v_d = 1'b1;
                            req_d   = mk_req(sotp_pkg::REQ_ERASE, 1'b0,
                                             ctx_q.addr, 8'h00);
                        end
                    end
                    default: ;
                endcase
            end else if (ctx_q.op == sotp_pkg::OP_SEC_WRITE
                      || ctx_q.op == sotp_pkg::OP_WRSR1
                      || ctx_q.op == sotp_pkg::OP_WRSR2
                      || ctx_q.op == sotp_pkg::OP_ERASE) begin
                ref_d = 1'b1;
            end
        end
        if (cs_s_q) begin
            ctx_d.state  = sotp_pkg::ST_CMD;
            ctx_d.bitcnt = 3'h0;
            ctx_d.acnt   = 2'h0;
            ctx_d.got    = 1'b0;
            ctx_d.oe     = 1'b0;
        end else if (sck_rise) begin
            ctx_d.shin   = rx_byte;
            ctx_d.bitcnt = ctx_q.bitcnt + 3'h1;
            if (ctx_q.bitcnt == sotp_pkg::BIT_LAST) begin
                case (ctx_q.state)
                    sotp_pkg::ST_CMD: begin
                        ctx_d.op = rx_byte;
                        case (rx_byte)
                            sotp_pkg::OP_OTP_ENTER: ctx_d.otp_mode = 1'b1;
                            sotp_pkg::OP_OTP_LEAVE: ctx_d.otp_mode = 1'b0;
                            sotp_pkg::OP_SEC_READ: begin
                                ctx_d.state  = sotp_pkg::ST_DATA;
                                ctx_d.txnext = sec_value;
                                ctx_d.oe     = 1'b1;
                            end
                            sotp_pkg::OP_SEC_WRITE, sotp_pkg::OP_WRSR1,
                            sotp_pkg::OP_WRSR2:
                                ctx_d.state = sotp_pkg::ST_DATA;
                            sotp_pkg::OP_READ, sotp_pkg::OP_PROG,
                            sotp_pkg::OP_ERASE, sotp_pkg::OP_PARAM:
                                ctx_d.state = sotp_pkg::ST_ADDR;
                            default: ;
                        endcase
                    end
                    sotp_pkg::ST_ADDR: begin
                        ctx_d.addr = {ctx_q.addr[15:0], rx_byte};
                        ctx_d.acnt = ctx_q.acnt + 2'h1;
                        if (ctx_q.acnt == sotp_pkg::ADDR_LAST_IDX) begin
                            if (ctx_q.op == sotp_pkg::OP_PARAM) begin
                                ctx_d.state = sotp_pkg::ST_DUMMY;
                            end else begin
                                ctx_d.state = sotp_pkg::ST_DATA;
                                ctx_d.got = (ctx_q.op == sotp_pkg::OP_ERASE);
                                if (ctx_q.op == sotp_pkg::OP_READ) begin
                                    ctx_d.oe = 1'b1;
                                    rd_go    = 1'b1;
                                    rd_addr  = ctx_d.addr;
                                end
                            end
                        end
                    end
                    sotp_pkg::ST_DUMMY: begin
                        ctx_d.state  = sotp_pkg::ST_DATA;
                        ctx_d.oe     = 1'b1;
                        ctx_d.txnext = param_byte(ctx_q.addr);
                    end
                    sotp_pkg::ST_DATA: begin
                        ctx_d.got  = 1'b1;
                        ctx_d.addr = ctx_q.addr + 24'h000001;
                        case (ctx_q.op)
                            sotp_pkg::OP_PROG: begin
                                if (ctx_q.otp_mode
                                    && (nv_factory_lock
                                        || otp_customer_lock_flag
                                        || ctx_q.addr
                                           > sotp_pkg::OTP_ADDR_LAST)) begin
                                    ref_d = 1'b1;
                                end else begin
                                    req_v_d = 1'b1;
                                    req_d   = mk_req(sotp_pkg::REQ_PROG,
                                                     ctx_q.otp_mode,
                                                     ctx_q.addr, rx_byte);
                                end
                            end
                            sotp_pkg::OP_READ: begin
                                rd_go   = 1'b1;
                                rd_addr = ctx_d.addr;
                            end
                            sotp_pkg::OP_PARAM:
                                ctx_d.txnext = param_byte(ctx_d.addr);
                            sotp_pkg::OP_SEC_READ:
                                ctx_d.txnext = sec_value;
                            default: ;
                        endcase
                    end
                    default: ctx_d.state = sotp_pkg::ST_CMD;
                endcase
            end
        end else if (sck_fall && ctx_q.oe) begin
            ctx_d.shout = (ctx_q.bitcnt == 3'h0) ? ctx_q.txnext
                                                 : {ctx_q.shout[6:0], 1'b0};
            ctx_d.miso  = ctx_d.shout[7];
        end
        if (rd_go) begin
            if (ctx_q.otp_mode && rd_addr > sotp_pkg::OTP_ADDR_LAST) begin
                ctx_d.txnext = sotp_pkg::BLANK_BYTE;
            end else begin
                req_v_d       = 1'b1;
                req_d         = mk_req(sotp_pkg::REQ_READ, ctx_q.otp_mode,
                                       rd_addr, 8'h00);
                ctx_d.rd_pend = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctx_q   <= '0;
            req_q   <= '0;
            req_v_q <= 1'b0;
            set_q   <= 1'b0;
            ref_q   <= 1'b0;
        end else begin
            ctx_q   <= ctx_d;
            req_q   <= req_d;
            req_v_q <= req_v_d;
            set_q   <= set_d;
            ref_q   <= ref_d;
        end
    end

    assign spi_miso      = ctx_q.miso;
    assign spi_miso_oe   = ctx_q.oe & ~cs_s_q;
    assign mem_req_valid = req_v_q;
    assign mem_req       = req_q;
    assign cust_lock_set = set_q;
    assign cmd_refused   = ref_q;
    assign otp_mode      = ctx_q.otp_mode;

endmodule : sotp_access

// ### src/sotp_pkg.sv
// Constants, opcodes and carrier types of the secured OTP command block.
// Behaviour
// - Opcode b1 enters OTP mode; later accesses target the 4 Kbit OTP area.
// - Opcode c1 leaves OTP mode; later accesses target the main array again.
// - In OTP mode ordinary read and program commands act on the OTP area.
// - In OTP mode status writes and security register writes are refused.
// - Once the OTP area is locked, programs to it are ignored.
// - No program or erase reaches the main array while OTP mode is on.
// - Opcode 2b returns the security register at any time, repeatedly.
// - Security bit 0 reports the non-volatile factory lock of the OTP area.
// - Security bit 1 is a set-only customer lock freezing itself and OTP.
// - Opcode 2f runs without any prior write enable.
// - A 2f not ended exactly on a byte boundary is rejected unchanged.
// - OTP decodes 000000-0001ff; the first 128 bits hold the serial number.
// - Parameter bytes 84 and 85 read da and 06; power-up unprotected.
package sotp_pkg;

    localparam logic [7:0] OP_OTP_ENTER = 8'hb1;
    localparam logic [7:0] OP_OTP_LEAVE = 8'hc1;
    localparam logic [7:0] OP_SEC_READ  = 8'h2b;
    localparam logic [7:0] OP_SEC_WRITE = 8'h2f;
    localparam logic [7:0] OP_WRSR1     = 8'h01;
    localparam logic [7:0] OP_WRSR2     = 8'h31;
    localparam logic [7:0] OP_READ      = 8'h03;
    localparam logic [7:0] OP_PROG      = 8'h02;
    localparam logic [7:0] OP_ERASE     = 8'h20;
    localparam logic [7:0] OP_PARAM     = 8'h5a;

    localparam logic [23:0] OTP_ADDR_LAST    = 24'h0001ff;
    localparam logic [23:0] SERIAL_ADDR_LAST = 24'h00000f;
    localparam logic [23:0] PARAM_PROT_ADDR0 = 24'h000084;
    localparam logic [23:0] PARAM_PROT_ADDR1 = 24'h000085;
    localparam logic [7:0]  PARAM_PROT_BYTE0 = 8'hda;
    localparam logic [7:0]  PARAM_PROT_BYTE1 = 8'h06;
    localparam logic [7:0]  BLANK_BYTE       = 8'hff;

    localparam int          SEC_FACTORY_BIT = 0;
    localparam int          SEC_CUST_BIT    = 1;
    localparam logic [5:0]  SEC_RSVD_VALUE  = 6'h00;
    localparam logic [2:0]  BIT_LAST        = 3'h7;
    localparam logic [1:0]  ADDR_LAST_IDX   = 2'h2;

    typedef enum logic [1:0] {
        ST_CMD   = 2'b00,
        ST_ADDR  = 2'b01,
        ST_DUMMY = 2'b11,
        ST_DATA  = 2'b10
    } sotp_state_type;

    typedef enum logic [2:0] {
        REQ_READ  = 3'h0,
        REQ_PROG  = 3'h1,
        REQ_ERASE = 3'h2,
        REQ_WRSR1 = 3'h3,
        REQ_WRSR2 = 3'h4
    } sotp_kind_type;

    typedef struct packed {
        sotp_kind_type kind;
        logic          otp_sel;
        logic          serial_number_field;
        logic [23:0]   addr;
        logic [7:0]    data;
    } sotp_req_type;

    typedef struct packed {
        sotp_state_type state;
        logic [7:0]     op;
        logic [2:0]     bitcnt;
        logic [1:0]     acnt;
        logic           got;
        logic [7:0]     shin;
        logic [7:0]     shout;
        logic [7:0]     txnext;
        logic [23:0]    addr;
        logic           otp_mode;
        logic           rd_pend;
        logic           miso;
        logic           oe;
    } sotp_ctx_type;

endpackage : sotp_pkg

// ### verif/sotp_access_chk.sv
// Port assertions for the secured OTP command block.
`timescale 1ns/100ps
module sotp_access_chk (
    // Device pins and side ports.
    input wire logic                   core_clk,
    input wire logic                   arst_n,
    input wire logic                   spi_cs_n,
    input wire logic                   spi_sck,
    input wire logic                   spi_mosi,
    input wire logic                   spi_miso,
    input wire logic                   spi_miso_oe,
    input wire logic                   nv_factory_lock,
    input wire logic                   otp_customer_lock_flag,
    input wire logic                   cust_lock_set,
    input wire logic                   mem_req_valid,
    input wire sotp_pkg::sotp_req_type mem_req,
    input wire logic [7:0]             mem_rdata,
    input wire logic                   otp_mode,
    input wire logic                   cmd_refused
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    sequence otp_prog_s;
        mem_req_valid && mem_req.otp_sel
            && mem_req.kind == sotp_pkg::REQ_PROG;
    endsequence
    sequence mode_req_s;
        mem_req_valid && otp_mode;
    endsequence
    chk_reset_normal: assert property ($rose(arst_n) |-> !otp_mode)
        else $error("OTP mode active after reset");
    chk_mode_idle: assert property ($changed(otp_mode) |->
        !spi_cs_n && !spi_miso_oe)
        else $error("OTP mode changed outside a command frame");
    chk_mode_target: assert property (mode_req_s |-> mem_req.otp_sel)
        else $error("main array request while in OTP mode");
    chk_main_target: assert property (mem_req_valid && !otp_mode |-> !mem_req.otp_sel)
        else $error("OTP request outside OTP mode");
    chk_mode_kinds: assert property (mode_req_s |-> mem_req.kind inside
        {sotp_pkg::REQ_READ, sotp_pkg::REQ_PROG})
        else $error("status write or erase issued in OTP mode");
    chk_otp_range: assert property (mem_req_valid && mem_req.otp_sel |->
        mem_req.addr <= 24'h0001ff
        && mem_req.serial_number_field == (mem_req.addr <= 24'h00000f))
        else $error("OTP request address out of range");
    chk_locked_prog: assert property (otp_prog_s |->
        !otp_customer_lock_flag && !nv_factory_lock)
        else $error("program of a locked OTP area");
    chk_lock_frozen: assert property (otp_customer_lock_flag[*2] |-> !cust_lock_set)
        else $error("customer lock programmed again");
    chk_pulse_single: assert property (cmd_refused |=> !cmd_refused)
        else $error("refusal pulse longer than one cycle");
    chk_oe_idle: assert property (spi_cs_n[*6] |-> !spi_miso_oe)
        else $error("data out driven while deselected");
endmodule : sotp_access_chk

// ### verif/sotp_host.sv
// SPI host model that frames mode 0 commands toward the device.
`timescale 1ns/100ps
module sotp_host (
    // Clock and serial pins.
    input  wire logic core_clk,
    output logic      spi_cs_n,
    output logic      spi_sck,
    output logic      spi_mosi,
    input  wire logic spi_miso,
    input  wire logic spi_miso_oe
);
    localparam int HALF = 6;
    logic [63:0] rx_q;
    initial begin
        spi_cs_n = 1'b1;
        spi_sck  = 1'b0;
        spi_mosi = 1'b0;
        rx_q     = 64'h0;
    end
    // Sends the top nbits of tx MSB first; data out bits gather in rx_q.
    task automatic frame(input logic [63:0] tx, input int nbits);
        spi_cs_n = 1'b0;
        repeat (HALF) @(negedge core_clk);
        for (int i = 0; i < nbits; i++) begin
            spi_mosi = tx[63-i];
            repeat (HALF) @(negedge core_clk);
            spi_sck = 1'b1;
            rx_q    = {rx_q[62:0], spi_miso};
            repeat (HALF) @(negedge core_clk);
            spi_sck = 1'b0;
        end
        repeat (HALF) @(negedge core_clk);
        spi_cs_n = 1'b1;
        // A released data line must not keep showing its last bit.
        spi_mosi = ~spi_mosi;
        repeat (10) @(negedge core_clk);
    endtask : frame
endmodule : sotp_host

// ### verif/sotp_access_test.sv
// Self-checking bench for the secured OTP command block.
`timescale 1ns/100ps
module sotp_access_test;
    logic                   core_clk, arst_n, spi_cs_n, spi_sck, spi_mosi;
    logic                   spi_miso, spi_miso_oe, nv_factory_lock;
    logic                   otp_customer_lock_flag = 1'b0, cust_lock_set;
    logic                   mem_req_valid, otp_mode, cmd_refused;
    logic [7:0]             mem_rdata = 8'h00;
    sotp_pkg::sotp_req_type mem_req, last_req;
    int                     bad_count, cmp_count, ref_cnt, lock_cnt, n;
    int                     req_cnt, m;
    logic [7:0]             bad_op [4] = '{8'h20, 8'h01, 8'h31, 8'h2f};

    sotp_access dut (.core_clk, .arst_n, .spi_cs_n, .spi_sck, .spi_mosi,
        .spi_miso, .spi_miso_oe, .nv_factory_lock, .otp_customer_lock_flag,
        .cust_lock_set, .mem_req_valid, .mem_req, .mem_rdata, .otp_mode,
        .cmd_refused);
    sotp_host host (.core_clk, .spi_cs_n, .spi_sck, .spi_mosi, .spi_miso,
        .spi_miso_oe);

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Memory engine and lock cell stand-in; read data marks its target.
    always @(negedge core_clk) begin
        if (mem_req_valid) begin
            last_req = mem_req;
            req_cnt++;
            mem_rdata <= mem_req.addr[7:0] ^ (mem_req.otp_sel ? 8'ha5 : 8'h5a);
        end
        if (cmd_refused) ref_cnt++;
        if (cust_lock_set) begin
            lock_cnt++;
            otp_customer_lock_flag <= 1'b1;
        end
    end

    task automatic check(input string what, input logic [39:0] seen,
                         input logic [39:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (40000) @(posedge core_clk);
        bad_count++;
        stop_test();
    end

    initial begin
        arst_n = 1'b0;
        nv_factory_lock = 1'b0;
        repeat (2) @(negedge core_clk);
        arst_n = 1'b1;
        repeat (6) @(negedge core_clk);
        check("mode_after_reset", otp_mode, 1'b0);
        host.frame({8'h2b, 56'h0}, 24);
        check("sec_read", host.rx_q[15:0], 16'h0000);
        host.frame({8'h5a, 24'h000084, 8'h00, 24'h0}, 56);
        check("param_bytes", host.rx_q[15:0], 16'hda06);
        host.frame({8'hb1, 56'h0}, 8);
        check("mode_enter", otp_mode, 1'b1);
        host.frame({8'h03, 24'h00000f, 32'h0}, 48);
        check("otp_read", host.rx_q[15:0], 16'haab5);
        check("otp_read_sel", last_req.otp_sel, 1'b1);
        host.frame({8'h03, 24'h000200, 32'h0}, 40);
        check("otp_read_high", host.rx_q[7:0], 8'hff);
        host.frame({8'h02, 24'h000010, 8'h3c, 24'h0}, 40);
        check("otp_prog", last_req, {sotp_pkg::REQ_PROG, 2'b10,
            24'h000010, 8'h3c});
        for (int i = 0; i < 4; i++) begin
            n = ref_cnt;
            m = req_cnt;
            host.frame({bad_op[i], 24'h020202, 32'h0}, 32);
            check("otp_refuse", ref_cnt - n, 1);
            check("otp_refuse_req", req_cnt - m, 0);
        end
        check("otp_refuse_lock", lock_cnt, 0);
        host.frame({8'hc1, 56'h0}, 8);
        check("mode_leave", otp_mode, 1'b0);
        host.frame({8'h02, 24'h000100, 8'h77, 24'h0}, 40);
        check("main_prog", last_req, {sotp_pkg::REQ_PROG, 2'b00,
            24'h000100, 8'h77});
        n = ref_cnt;
        host.frame({8'h2f, 8'h02, 48'h0}, 19);
        check("lock_partial", lock_cnt, 0);
        check("lock_partial_ref", ref_cnt - n, 1);
        host.frame({8'h2f, 8'h02, 48'h0}, 16);
        check("lock_set", lock_cnt, 1);
        nv_factory_lock = 1'b1;
        host.frame({8'h2b, 56'h0}, 24);
        check("sec_locked", host.rx_q[15:0], 16'h0303);
        n = ref_cnt;
        host.frame({8'h2f, 8'h02, 48'h0}, 16);
        check("lock_again", ref_cnt - n, 1);
        host.frame({8'hb1, 56'h0}, 8);
        n = ref_cnt;
        host.frame({8'h02, 24'h000020, 8'h11, 24'h0}, 40);
        check("locked_prog", ref_cnt - n, 1);
        host.frame({8'h03, 24'h000010, 32'h0}, 40);
        check("locked_read", host.rx_q[7:0], 8'hb5);
        // A mid-run reset drops OTP mode but keeps the non-volatile locks.
        arst_n = 1'b0;
        repeat (2) @(negedge core_clk);
        arst_n = 1'b1;
        repeat (6) @(negedge core_clk);
        check("mode_after_rerun", otp_mode, 1'b0);
        host.frame({8'h2b, 56'h0}, 24);
        check("sec_after_rerun", host.rx_q[15:0], 16'h0303);
        stop_test();
    end
endmodule : sotp_access_test

bind sotp_access sotp_access_chk chk (.core_clk, .arst_n, .spi_cs_n,
    .spi_sck, .spi_mosi, .spi_miso, .spi_miso_oe, .nv_factory_lock,
    .otp_customer_lock_flag, .cust_lock_set, .mem_req_valid, .mem_req,
    .mem_rdata, .otp_mode, .cmd_refused);
